// File: design/fesq_seq.sv
// Flash erase-block, erase-sector, unsecure and wipe-pin sequencer.
// Assumes the array takes a one-cycle request and pulses done later.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module fesq_seq
  import fesq_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // System wipe request
  input wire logic ERASE_ALL_REQ,
  // Flash array
  output fesq_areq_t ARRAY_REQ,
  input wire fesq_arsp_t ARRAY_RSP,
  // Status
  output logic WIPE_ACTIVE
);

  typedef struct packed {
    fesq_st_t st;
    logic [6:0] div;
    logic divld;
    logic cmpl;
    logic acc;
    logic pv;
    logic ve;
    logic ue;
    logic wipe;
    logic wpend;
    logic wprev;
    logic unsec;
    logic [2:0] idx;
    logic [1:0][15:0] words;
    logic [1:0] lock;
    logic [1:0] prot;
    logic special;
    logic [15:0] rdata;
    fesq_areq_t areq;
  } fesq_state_t;

  fesq_state_t q;
  fesq_state_t d;
  fesq_bus_t bus;
  logic launch;
  logic [7:0] opc;
  logic [23:0] gaddr;
  logic bad_acc;
  logic bad_prot;

  function automatic logic in_pf(input logic [23:0] a);
    in_pf = (a >= PF_LO) && (a <= PF_HI);
  endfunction

  function automatic logic in_ee(input logic [23:0] a);
    in_ee = (a >= EE_LO) && (a <= EE_HI);
  endfunction

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign opc = q.words[0][15:8];
  assign gaddr = {q.words[0][7:0], q.words[1]};

  always_comb
  begin
    d = q;
    d.areq.req = 1'b0;
    d.rdata = 16'h0000;
    launch = 1'b0;
    bad_acc = 1'b0;
    bad_prot = 1'b0;
    d.wprev = ERASE_ALL_REQ;
    if (ERASE_ALL_REQ && !q.wprev)
    begin
      d.wpend = 1'b1;
    end
    // Register reads, data in next cycle
    if (bus.rd)
    begin
      case (bus.addr)
        REG_DIV: d.rdata = {8'h00, q.divld, q.div};
        REG_STAT: d.rdata = {8'h00, q.cmpl, 1'b0, q.acc, q.pv,
                             2'b00, q.ve, q.ue};
        REG_CNFG: d.rdata = {15'h0000, q.wipe};
        REG_IDX: d.rdata = {13'h0000, q.idx};
        REG_WORD: d.rdata = q.words[q.idx[0]];
        REG_LOCK: d.rdata = {14'h0000, q.lock};
        REG_PROT: d.rdata = {14'h0000, q.prot};
        REG_MODE: d.rdata = {15'h0000, q.special};
        default: d.rdata = 16'h0000;
      endcase
    end
    // Register writes, only while idle
    if (bus.wr && q.cmpl && q.st == ST_IDLE)
    begin
      case (bus.addr)
        REG_DIV:
        begin
          d.div = bus.wdata[6:0];
          d.divld = 1'b1;
        end
        REG_STAT:
        begin
          if (bus.wdata[STAT_ACC])
            d.acc = 1'b0;
          if (bus.wdata[STAT_PV])
            d.pv = 1'b0;
          launch = bus.wdata[STAT_CMPL] && !q.acc && !q.pv;
        end
        REG_IDX: d.idx = bus.wdata[2:0];
        REG_WORD:
        begin
          if (q.idx <= IDX_ADDR)
            d.words[q.idx[0]] = bus.wdata;
        end
        REG_PROT: d.prot = bus.wdata[1:0];
        REG_MODE: d.special = bus.wdata[0];
        default: d.special = q.special;
      endcase
    end
    case (q.st)
      ST_IDLE:
      begin
        if (q.wpend && q.cmpl)
        begin
          d.wpend = 1'b0;
          if (!q.divld)
          begin
            d.acc = 1'b1;
          end
          else
          begin
            // Protection deliberately not consulted
            d.wipe = 1'b1;
            d.unsec = 1'b1;
            d.cmpl = 1'b0;
            d.ve = 1'b0;
            d.ue = 1'b0;
            d.areq = '{req: 1'b1, op: OP_ERS_ALL, addr: 24'h000000};
            d.st = ST_ERASE;
          end
        end
        else if (launch)
        begin
          d.ve = 1'b0;
          d.ue = 1'b0;
          bad_acc = !q.divld;
          case (opc)
            CMD_ERS_BLK:
            begin
              bad_acc = bad_acc || q.idx != IDX_ADDR;
              bad_acc = bad_acc || !(in_pf(gaddr) || in_ee(gaddr));
              bad_acc = bad_acc || (in_pf(gaddr) && gaddr[2:0] != 3'h0);
              bad_acc = bad_acc || (in_ee(gaddr) && gaddr[0]);
              bad_prot = in_pf(gaddr) ? q.prot[0] : q.prot[1];
              d.areq = '{req: 1'b1, op: OP_ERS_BLK, addr: gaddr};
            end
            CMD_ERS_SECT:
            begin
              bad_acc = bad_acc || q.idx != IDX_ADDR;
              bad_acc = bad_acc || !in_pf(gaddr);
              bad_acc = bad_acc || gaddr[2:0] != 3'h0;
              bad_prot = q.prot[0];
              d.areq = '{req: 1'b1, op: OP_ERS_SECT, addr: gaddr};
            end
            CMD_UNSEC:
            begin
              bad_acc = bad_acc || q.idx != IDX_NONE;
              bad_acc = bad_acc || !q.special;
              bad_prot = |q.prot;
              d.areq = '{req: 1'b1, op: OP_ERS_ALL,
                         addr: 24'h000000};
            end
            default: bad_acc = 1'b1;
          endcase
          if (bad_acc)
          begin
            d.acc = 1'b1;
            d.areq.req = 1'b0;
          end
          else if (bad_prot)
          begin
            d.pv = 1'b1;
            d.areq.req = 1'b0;
          end
          else
          begin
            d.cmpl = 1'b0;
            d.unsec = opc == CMD_UNSEC;
            d.st = ST_ERASE;
          end
        end
      end
      ST_ERASE:
      begin
        if (ARRAY_RSP.done)
        begin
          d.areq.req = 1'b1;
          d.areq.op = q.areq.op | OP_VFY;
          d.st = ST_VFY;
        end
      end
      ST_VFY:
      begin
        if (ARRAY_RSP.done)
        begin
          d.ve = ARRAY_RSP.err;
          d.ue = ARRAY_RSP.err && ARRAY_RSP.uncorr;
          if (q.unsec && !ARRAY_RSP.err)
          begin
            d.lock = LOCK_UNSEC;
          end
          if (q.wipe && !ARRAY_RSP.err)
          begin
            d.areq = '{req: 1'b1, op: OP_PROG_LOCK,
                       addr: 24'h000000};
            d.st = ST_PROG;
          end
          else
          begin
            d.st = ST_IDLE;
            d.cmpl = 1'b1;
            d.unsec = 1'b0;
            if (q.wipe)
            begin
              d.wipe = 1'b0;
              d.div = DIV_RST;
              d.divld = 1'b0;
            end
          end
        end
      end
      ST_PROG:
      begin
        if (ARRAY_RSP.done)
        begin
          d.ve = ARRAY_RSP.err;
          d.ue = ARRAY_RSP.err && ARRAY_RSP.uncorr;
          d.st = ST_IDLE;
          d.cmpl = 1'b1;
          d.unsec = 1'b0;
          d.wipe = 1'b0;
          d.div = DIV_RST;
          d.divld = 1'b0;
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.cmpl <= 1'b1;
      q.div <= DIV_RST;
      q.lock <= LOCK_SECURE;
    end
    else
    begin
      q <= d;
    end
  end

  assign RDATA = q.rdata;
  assign ARRAY_REQ = q.areq;
  assign WIPE_ACTIVE = q.wipe;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_launch_ok;
    q.st == ST_IDLE && !q.wpend && launch && !bad_acc && !bad_prot;
  endsequence

  sequence s_wipe_go;
    q.st == ST_IDLE && q.wpend && q.cmpl && q.divld;
  endsequence

  property p_launch_clears;
    s_launch_ok |=> !q.cmpl && q.st == ST_ERASE && q.areq.req;
  endproperty
  a_launch_clears: assert property (p_launch_clears)
    else $error("launch did not clear complete flag");

  property p_wipe_nodiv;
    q.st == ST_IDLE && q.wpend && q.cmpl && !q.divld
      |=> q.acc && q.st == ST_IDLE && !q.wipe;
  endproperty
  a_wipe_nodiv: assert property (p_wipe_nodiv)
    else $error("wipe ran without divider");

  property p_wipe_start;
    s_wipe_go |=> q.wipe && q.areq.req && q.areq.op == OP_ERS_ALL;
  endproperty
  a_wipe_start: assert property (p_wipe_start)
    else $error("wipe request not started");

  property p_wipe_busy;
    q.wipe |-> !q.cmpl && q.st != ST_IDLE;
  endproperty
  a_wipe_busy: assert property (p_wipe_busy)
    else $error("wipe bit set while idle");

  property p_wipe_end_div;
    $fell(q.wipe) |-> !q.divld && q.div == DIV_RST && q.cmpl;
  endproperty
  a_wipe_end_div: assert property (p_wipe_end_div)
    else $error("divider not reset after wipe");

  property p_wipe_prot;
    q.wipe |=> $stable(q.prot);
  endproperty
  a_wipe_prot: assert property (p_wipe_prot)
    else $error("protection changed by wipe");

  property p_vfy_fail_lock;
    q.st == ST_VFY && ARRAY_RSP.done && ARRAY_RSP.err
      |=> q.ve && $stable(q.lock) && q.cmpl;
  endproperty
  a_vfy_fail_lock: assert property (p_vfy_fail_lock)
    else $error("verify failure handled wrongly");

  property p_sect_misalign;
    q.st == ST_IDLE && !q.wpend && launch && opc == CMD_ERS_SECT
      && gaddr[2:0] != 3'h0 |=> q.acc && q.cmpl && !q.areq.req;
  endproperty
  a_sect_misalign: assert property (p_sect_misalign)
    else $error("misaligned sector erase accepted");

  property p_blk_prot;
    q.st == ST_IDLE && !q.wpend && launch && opc == CMD_ERS_BLK
      && !bad_acc && bad_prot |=> q.pv && q.cmpl && !q.areq.req;
  endproperty
  a_blk_prot: assert property (p_blk_prot)
    else $error("protected block erase accepted");

  property p_unsec_done;
    q.unsec && q.st == ST_VFY && ARRAY_RSP.done && !ARRAY_RSP.err
      |=> q.lock == LOCK_UNSEC;
  endproperty
  a_unsec_done: assert property (p_unsec_done)
    else $error("lock not released after good verify");

endmodule

// File: include/fesq_pkg.sv
// Package for the flash erase/unsecure command sequencer.
// Assumes one 50 MHz clock and a flash array that answers with done.
// How it works
// - Wipe request input runs erase-all, no software
// - Divider not loaded: refuse wipe, set access error
// - After wipe, divider reset; software reloads it
// - Wipe erases everything, ignoring protection
// - Wipe verify pass: unlock and program lock byte
// - Wipe status bit high while wipe runs
// - Wipe leaves protection setting untouched
// - Wipe verify errors set verify/uncorrectable flags
// - Code 09 erases and verifies addressed block
// - Block erase: bad index/address/alignment, access error
// - Block erase: protected block, violation, no erase
// - Code 0A erases and verifies addressed sector
// - Sector erase: misaligned access error, protected violation
// - Code 0B erases all; unlock on verify pass
// - Unsecure verify fails: verify error, lock unchanged
// - Unsecure: index not 000 or protection, flags
// - Verify errors set verify/uncorrectable flags
// - Command not allowed in mode: access error
// - Clearing complete flag launches; set when finished
package fesq_pkg;
  localparam logic [2:0] REG_DIV = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_CNFG = 3'h2;
  localparam logic [2:0] REG_IDX = 3'h3;
  localparam logic [2:0] REG_WORD = 3'h4;
  localparam logic [2:0] REG_LOCK = 3'h5;
  localparam logic [2:0] REG_PROT = 3'h6;
  localparam logic [2:0] REG_MODE = 3'h7;
  localparam int STAT_CMPL = 7;
  localparam int STAT_ACC = 5;
  localparam int STAT_PV = 4;
  localparam int STAT_VE = 1;
  localparam int STAT_UE = 0;
  localparam int DIV_LD = 7;
  localparam logic [6:0] DIV_RST = 7'h00;
  localparam logic [1:0] LOCK_SECURE = 2'h3;
  localparam logic [1:0] LOCK_UNSEC = 2'h2;
  localparam logic [7:0] CMD_ERS_BLK = 8'h09;
  localparam logic [7:0] CMD_ERS_SECT = 8'h0a;
  localparam logic [7:0] CMD_UNSEC = 8'h0b;
  localparam logic [2:0] IDX_ADDR = 3'h1;
  localparam logic [2:0] IDX_NONE = 3'h0;
  localparam logic [23:0] PF_LO = 24'he00000;
  localparam logic [23:0] PF_HI = 24'hffffff;
  localparam logic [23:0] EE_LO = 24'h100000;
  localparam logic [23:0] EE_HI = 24'h1007ff;
  localparam logic [2:0] OP_ERS_BLK = 3'h1;
  localparam logic [2:0] OP_ERS_SECT = 3'h2;
  localparam logic [2:0] OP_ERS_ALL = 3'h3;
  localparam logic [2:0] OP_PROG_LOCK = 3'h4;
  localparam logic [2:0] OP_VFY = 3'h4;
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } fesq_bus_t;
  typedef struct packed {
    logic req;
    logic [2:0] op;
    logic [23:0] addr;
  } fesq_areq_t;
  typedef struct packed {
    logic done;
    logic err;
    logic uncorr;
  } fesq_arsp_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ERASE = 4'h2,
    ST_VFY = 4'h4,
    ST_PROG = 4'h8
  } fesq_st_t;
endpackage

// File: tb/fesq_array_model.sv
// Flash array stand-in for the erase/unsecure sequencer bench.
// Assumes one-cycle requests; answers each after DELAY cycles.
`timescale 1ns/1ps
module fesq_array_model
  import fesq_pkg::*;
#(
  parameter int DELAY = 6
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Array request and answer
  input wire fesq_areq_t areq,
  output fesq_arsp_t arsp,
  // Verify fault injection
  input wire logic fail
);
  int cnt;
  logic vfy;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      vfy <= 1'b0;
      arsp <= '0;
    end
    else
    begin
      if (areq.req)
      begin
        cnt <= DELAY;
        vfy <= areq.op > OP_VFY;
      end
      else if (cnt > 0)
        cnt <= cnt - 1;
      arsp.done <= cnt == 1;
      // Error lines wander outside the done cycle
      arsp.err <= (cnt == 1) ? (vfy & fail) : ~arsp.err;
      arsp.uncorr <= (cnt == 1) ? (vfy & fail) : ~arsp.uncorr;
    end
  end
endmodule

// File: tb/tb.sv
// Self-checking bench for the flash erase/unsecure sequencer.
// Assumes the array model answers every request after a fixed delay.
`timescale 1ns/1ps
module tb;
  import fesq_pkg::*;
  logic CLOCK;
  logic RESET_N;
  logic [2:0] ADDR;
  logic [15:0] WDATA;
  logic WR;
  logic RD;
  logic [15:0] RDATA;
  logic ERASE_ALL_REQ;
  fesq_areq_t ARRAY_REQ;
  fesq_arsp_t ARRAY_RSP;
  logic WIPE_ACTIVE;
  logic fail;
  logic [15:0] ops;
  logic [23:0] last_addr;
  logic [15:0] s;
  logic busy;
  int err_count;
  int comparisons;
  int cycles;
  fesq_seq DUT (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .ERASE_ALL_REQ(ERASE_ALL_REQ), .ARRAY_REQ(ARRAY_REQ),
    .ARRAY_RSP(ARRAY_RSP), .WIPE_ACTIVE(WIPE_ACTIVE));
  fesq_array_model array (.clk(CLOCK), .rst_n(RESET_N),
    .areq(ARRAY_REQ), .arsp(ARRAY_RSP), .fail(fail));
  initial
  begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  // Log of array op codes, one nibble each
  always @(posedge CLOCK)
    if (ARRAY_REQ.req)
    begin
      ops <= {ops[11:0], 1'b0, ARRAY_REQ.op};
      last_addr <= ARRAY_REQ.addr;
    end
  always @(posedge CLOCK)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [15:0] e,
    input string n);
    logic [15:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask
  task automatic setf(input logic v);
    @(posedge CLOCK);
    fail <= v;
  endtask
  task automatic cmd(input logic [15:0] w0, w1, input logic [2:0] ix);
    @(posedge CLOCK);
    ops <= '0;
    wr(REG_IDX, 16'h0000);
    wr(REG_WORD, w0);
    wr(REG_IDX, 16'h0001);
    wr(REG_WORD, w1);
    wr(REG_IDX, {13'h0000, ix});
    wr(REG_STAT, 16'h0080);
    rd(REG_STAT, s);
    busy = !s[7];
    // Only reads while the command runs
    for (int i = 0; i < 40 && !s[7]; i++)
      rd(REG_STAT, s);
  endtask
  task automatic res(input string n, input logic [15:0] es, eo);
    chk(n, es, s);
    chk({n, "_ops"}, eo, ops);
    wr(REG_STAT, 16'h0030);
  endtask
  task automatic t_init;
    rchk(REG_STAT, 16'h0080, "stat");
    rchk(REG_CNFG, 16'h0000, "cnfg");
    rchk(REG_LOCK, 16'h0003, "lock");
    cmd(16'h09e0, 16'h0000, 3'h1);
    res("nodiv", 16'h00a0, 16'h0000);
  endtask
  task automatic t_blk;
    logic [15:0] w0 [4] = '{16'h09e0, 16'h09e0, 16'h0900, 16'h0910};
    logic [15:0] w1 [4] = '{16'h0000, 16'h0001, 16'h0000, 16'h0001};
    logic [2:0] ix [4] = '{3'h0, 3'h1, 3'h1, 3'h1};
    wr(REG_DIV, 16'h0085);
    cmd(16'h09e0, 16'h0108, 3'h1);
    res("blk", 16'h0080, 16'h0015);
    chk("busy", 16'h0001, {15'h0000, busy});
    chk("addr", 16'he001, last_addr[23:8]);
    for (int k = 0; k < 4; k++)
    begin
      cmd(w0[k], w1[k], ix[k]);
      res("blk_acc", 16'h00a0, 16'h0000);
    end
    wr(REG_PROT, 16'h0001);
    cmd(16'h09e0, 16'h0000, 3'h1);
    res("blk_pv", 16'h0090, 16'h0000);
    wr(REG_PROT, 16'h0000);
  endtask
  task automatic t_sect;
    cmd(16'h0ae0, 16'h0108, 3'h1);
    res("sect", 16'h0080, 16'h0026);
    cmd(16'h0ae0, 16'h0104, 3'h1);
    res("sect_acc", 16'h00a0, 16'h0000);
    wr(REG_PROT, 16'h0001);
    cmd(16'h0ae0, 16'h0108, 3'h1);
    res("sect_pv", 16'h0090, 16'h0000);
    wr(REG_PROT, 16'h0000);
    setf(1'b1);
    cmd(16'h0ae0, 16'h0108, 3'h1);
    setf(1'b0);
    res("sect_ve", 16'h0083, 16'h0026);
  endtask
  task automatic t_uns;
    cmd(16'h0b00, 16'h0000, 3'h0);
    res("uns_mode", 16'h00a0, 16'h0000);
    cmd(16'h0c00, 16'h0000, 3'h0);
    res("bad_code", 16'h00a0, 16'h0000);
    wr(REG_MODE, 16'h0001);
    cmd(16'h0b00, 16'h0000, 3'h1);
    res("uns_idx", 16'h00a0, 16'h0000);
    wr(REG_PROT, 16'h0002);
    cmd(16'h0b00, 16'h0000, 3'h0);
    res("uns_pv", 16'h0090, 16'h0000);
    wr(REG_PROT, 16'h0000);
    setf(1'b1);
    cmd(16'h0b00, 16'h0000, 3'h0);
    setf(1'b0);
    res("uns_ve", 16'h0083, 16'h0037);
    rchk(REG_LOCK, 16'h0003, "lock_kept");
    cmd(16'h0b00, 16'h0000, 3'h0);
    res("uns", 16'h0080, 16'h0037);
    rchk(REG_LOCK, 16'h0002, "lock_free");
  endtask
  task automatic do_reset;
    @(posedge CLOCK);
    RESET_N <= 1'b0;
    repeat (4) @(posedge CLOCK);
    RESET_N <= 1'b1;
  endtask
  task automatic wipe;
    @(posedge CLOCK);
    ops <= '0;
    ERASE_ALL_REQ <= 1'b1;
    repeat (3) @(posedge CLOCK);
    ERASE_ALL_REQ <= 1'b0;
  endtask
  task automatic wipe_end;
    for (int i = 0; i < 100 && WIPE_ACTIVE; i++)
    begin
      @(posedge CLOCK);
      #1;
    end
  endtask
  task automatic t_wipe;
    do_reset;
    wipe;
    repeat (8) @(posedge CLOCK);
    chk("wipe_nodiv_ops", 16'h0000, ops);
    rchk(REG_STAT, 16'h00a0, "wipe_nodiv");
    wr(REG_STAT, 16'h0030);
    wr(REG_DIV, 16'h0085);
    wr(REG_PROT, 16'h0003);
    wipe;
    rchk(REG_CNFG, 16'h0001, "wipe_bit");
    chk("wipe_pin", 16'h0001, {15'h0000, WIPE_ACTIVE});
    wipe_end;
    chk("wipe_pin_end", 16'h0000, {15'h0000, WIPE_ACTIVE});
    chk("wipe_ops", 16'h0374, ops);
    rchk(REG_LOCK, 16'h0002, "wipe_lock");
    rchk(REG_PROT, 16'h0003, "wipe_prot");
    rchk(REG_STAT, 16'h0080, "wipe_stat");
    rchk(REG_DIV, 16'h0000, "wipe_div");
    cmd(16'h0ae0, 16'h0108, 3'h1);
    res("after_wipe", 16'h00a0, 16'h0000);
  endtask
  task automatic t_wipe_fail;
    do_reset;
    wr(REG_DIV, 16'h0085);
    setf(1'b1);
    wipe;
    wipe_end;
    setf(1'b0);
    chk("wipe_ve_ops", 16'h0037, ops);
    rchk(REG_STAT, 16'h0083, "wipe_ve");
    rchk(REG_LOCK, 16'h0003, "wipe_ve_lock");
  endtask
  initial
  begin
    RESET_N = 1'b0;
    ADDR = 3'h0;
    WDATA = 16'h0000;
    WR = 1'b0;
    RD = 1'b0;
    ERASE_ALL_REQ = 1'b0;
    fail = 1'b0;
    ops = '0;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (4) @(posedge CLOCK);
    RESET_N <= 1'b1;
    t_init;
    t_blk;
    t_sect;
    t_uns;
    t_wipe;
    t_wipe_fail;
    tally_and_finish;
  end
endmodule
